// [hdl/acsp_defines.vh]
//
// Contract
// - Port uses exactly three signals: serial clock, active-low select, one data line.
// - Every data bit in or out is timed by the serial clock.
// - Transfers happen only while select is low; select high gates them off.
// - A frame starts at the first rising clock edge after select falls.
// - Select held low streams consecutive bytes without limit. Code streams only when both word-length bits are set.
// - Select raised between bytes pauses; the frame resumes at the next byte. Code resumes only if select returns low within HIGH_IDLE_CYC cycles.
// - Select held high puts the port pins in high impedance, secondary use on.
// - Each frame opens with a 16-bit instruction decoded before any data.
// - Two word-length bits in the instruction set the number of data bytes.
// - Data after the instruction moves in whole 8-bit bytes only.
// - The first bit of the stream is the read-or-write flag.
// - On read the data line turns to output and returns register contents.
// - Bits shift MSB first after reset; a config bit selects LSB first. lsb_first orders data bits and sets address step direction; the instruction stays MSB first.
// - Serial clock and select are always inputs; the device never drives them.
// - Data line is input in write phases, output in readback; host releases it.
// - Read with both channel bits set returns the first channel's local register.
`ifndef ACSP_DEFINES_VH
`define ACSP_DEFINES_VH
`define ACSP_INSTR_BITS 5'h10
`define ACSP_BYTE_BITS 4'h8
`define ACSP_RW_BIT 4'hF
`define ACSP_LEN_HI_BIT 4'hE
`define ACSP_LEN_LO_BIT 4'hD
`define ACSP_LEN_STREAM 2'h3
`define ACSP_ADDR_MSB 4'hC
`define ACSP_CHAN_A_BIT 1'h0
`define ACSP_CHAN_B_BIT 1'h1
`define ACSP_HIGH_IDLE_CYC 16'h0100
`endif

// [hdl/acsp_serial_port.v]
`timescale 1ns/10ps
`include "acsp_defines.vh"
module acsp_serial_port #(
   parameter ADDR_W = 13,
   parameter HIGH_IDLE_CYC = `ACSP_HIGH_IDLE_CYC
) (
   input wire sys_clk,
   input wire rst,
   input wire sclk,
   input wire cs_n,
   input wire sdio_i,
   output reg sdio_o,
   output reg sdio_oe,
   input wire lsb_first,
   input wire [1:0] chan_sel,
   input wire [7:0] rd_data_a,
   input wire [7:0] rd_data_b,
   output reg [ADDR_W-1:0] reg_addr,
   output reg [1:0] reg_chan,
   output reg [7:0] wr_data,
   output reg wr_stb,
   output reg rd_stb,
   output reg port_hiz,
   output reg busy
);
   localparam ST_IDLE = 2'h0;
   localparam ST_INSTR = 2'h1;
   localparam ST_DATA = 2'h2;
   // Two-flop synchronisers; first stage read only by second
   reg sclk_m_r, sclk_s_r, sclk_d_r;
   reg cs_m_r, cs_s_r, cs_d_r;
   reg sdi_m_r, sdi_s_r;
   reg [1:0] st_r;
   reg [4:0] bit_cnt_r;
   reg [15:0] instr_r;
   reg [7:0] shin_r;
   reg [7:0] shout_r;
   reg [2:0] left_r;
   reg rd_r;
   reg [15:0] hi_cnt_r;
   reg [ADDR_W-1:0] addr_nxt;
   reg [7:0] rd_sel;
   wire rise;
   wire fall;
   wire active;
   wire [15:0] instr_nxt;
   wire [7:0] byte_nxt;
   assign rise = sclk_s_r & ~sclk_d_r & ~cs_s_r;
   assign fall = ~sclk_s_r & sclk_d_r & ~cs_s_r;
   assign active = ~cs_s_r;
   // Shift direction picks where a new data bit lands; instruction bits always enter at bit 0
   assign instr_nxt = {instr_r[14:0], sdi_s_r};
   assign byte_nxt = lsb_first ? {sdi_s_r, shin_r[7:1]} : {shin_r[6:0], sdi_s_r};
   always @* begin
      addr_nxt = instr_r[ADDR_W-1:0];
      if (lsb_first) begin
         addr_nxt = reg_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
      end else begin
         addr_nxt = reg_addr - {{(ADDR_W-1){1'b0}}, 1'b1};
      end
   end
   always @* begin
      // Channel A wins when both are selected
      if (chan_sel[`ACSP_CHAN_A_BIT]) begin
         rd_sel = rd_data_a;
      end else if (chan_sel[`ACSP_CHAN_B_BIT]) begin
         rd_sel = rd_data_b;
      end else begin
         rd_sel = rd_data_a;
      end
   end
   always @(posedge sys_clk) begin
      if (rst) begin
         sclk_m_r <= 1'b0;
         sclk_s_r <= 1'b0;
         sclk_d_r <= 1'b0;
         cs_m_r <= 1'b1;
         cs_s_r <= 1'b1;
         cs_d_r <= 1'b1;
         sdi_m_r <= 1'b0;
         sdi_s_r <= 1'b0;
      end else begin
         sclk_m_r <= sclk;
         sclk_s_r <= sclk_m_r;
         sclk_d_r <= sclk_s_r;
         cs_m_r <= cs_n;
         cs_s_r <= cs_m_r;
         cs_d_r <= cs_s_r;
         sdi_m_r <= sdio_i;
         sdi_s_r <= sdi_m_r;
      end
   end
   always @(posedge sys_clk) begin
      if (rst) begin
         st_r <= ST_IDLE;
         bit_cnt_r <= 5'h00;
         instr_r <= 16'h0000;
         shin_r <= 8'h00;
         shout_r <= 8'h00;
         left_r <= 3'h0;
         rd_r <= 1'b0;
         hi_cnt_r <= 16'h0000;
         sdio_o <= 1'b0;
         sdio_oe <= 1'b0;
         reg_addr <= {ADDR_W{1'b0}};
         reg_chan <= 2'h0;
         wr_data <= 8'h00;
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         port_hiz <= 1'b1;
         busy <= 1'b0;
      end else begin
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         // Step only after the strobe, so a write shows its own address
         if (wr_stb) begin
            reg_addr <= addr_nxt;
         end
         // Long select-high stretch means no frame; pins go quiet
         if (active) begin
            hi_cnt_r <= 16'h0000;
            port_hiz <= 1'b0;
         end else if (hi_cnt_r < HIGH_IDLE_CYC) begin
            hi_cnt_r <= hi_cnt_r + 16'h0001;
         end else begin
            port_hiz <= 1'b1;
         end
         // Select high pauses the frame but keeps position; device never drives sclk/cs
         if (!active) begin
            sdio_oe <= 1'b0;
         end else if (st_r == ST_DATA && rd_r) begin
            // Held until select rises, so the last bit survives the host's sample
            sdio_oe <= 1'b1;
         end
         // A falling select after a long gap opens a new frame
         if (!cs_s_r && cs_d_r && port_hiz) begin
            st_r <= ST_INSTR;
            bit_cnt_r <= 5'h00;
            busy <= 1'b1;
         end else if (st_r == ST_IDLE && !cs_s_r && cs_d_r) begin
            st_r <= ST_INSTR;
            bit_cnt_r <= 5'h00;
            busy <= 1'b1;
         end else begin
            case (st_r)
               ST_IDLE: begin
                  busy <= 1'b0;
               end
               ST_INSTR: begin
                  if (rise) begin
                     instr_r <= instr_nxt;
                     if (bit_cnt_r == `ACSP_INSTR_BITS - 5'h01) begin
                        st_r <= ST_DATA;
                        bit_cnt_r <= 5'h00;
                        rd_r <= instr_nxt[`ACSP_RW_BIT];
                        left_r <= {1'b0, instr_nxt[`ACSP_LEN_HI_BIT:`ACSP_LEN_LO_BIT]};
                        reg_addr <= instr_nxt[ADDR_W-1:0];
                        reg_chan <= chan_sel;
                        if (instr_nxt[`ACSP_RW_BIT]) begin
                           rd_stb <= 1'b1;
                           shout_r <= rd_sel;
                        end
                     end else begin
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                     end
                  end
               end
               ST_DATA: begin
                  if (rd_r && fall) begin
                     // Host samples on rising edges, so update on falling
                     sdio_o <= lsb_first ? shout_r[0] : shout_r[7];
                     shout_r <= lsb_first ? {1'b0, shout_r[7:1]} : {shout_r[6:0], 1'b0};
                  end
                  if (rise) begin
                     shin_r <= byte_nxt;
                     if (bit_cnt_r[3:0] == `ACSP_BYTE_BITS - 4'h1) begin
                        bit_cnt_r <= 5'h00;
                        if (!rd_r) begin
                           wr_data <= byte_nxt;
                           wr_stb <= 1'b1;
                        end
                        if (rd_r) begin
                           reg_addr <= addr_nxt;
                           rd_stb <= 1'b1;
                        end
                        // Streaming length runs while select stays low
                        if (left_r[1:0] == 2'h0 && instr_r[`ACSP_LEN_HI_BIT:`ACSP_LEN_LO_BIT]
                            != `ACSP_LEN_STREAM) begin
                           st_r <= ST_IDLE;
                        end else if (left_r[1:0] != 2'h0 && instr_r[`ACSP_LEN_HI_BIT:`ACSP_LEN_LO_BIT]
                            != `ACSP_LEN_STREAM) begin
                           left_r <= left_r - 3'h1;
                        end else begin
                           left_r <= left_r;
                        end
                     end else begin
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                        if (bit_cnt_r[3:0] == 4'h0 && rd_r) begin
                           shout_r <= shout_r;
                        end
                     end
                  end
                  if (rd_r && rd_stb) begin
                     shout_r <= rd_sel;
                  end
               end
               default: begin
                  st_r <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule // acsp_serial_port

// [sim/acsp_serial_port_sva.sv]
`timescale 1ns/10ps
module acsp_serial_port_sva (
   input wire sys_clk,
   input wire rst,
   input wire sclk,
   input wire cs_n,
   input wire sdio_o,
   input wire sdio_oe,
   input wire wr_stb,
   input wire rd_stb,
   input wire port_hiz,
   input wire busy
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Six cycles covers the select synchroniser
   sequence s_desel; cs_n [*6]; endsequence
   sequence s_still; $stable(sclk) [*8]; endsequence
   chk_oe_desel: assert property (s_desel |-> !sdio_oe)
      else $error("oe deselected");
   chk_clk_timed: assert property (s_still |-> !wr_stb && !rd_stb)
      else $error("strobe no clock");
   chk_wr_pulse: assert property (wr_stb |=> !wr_stb)
      else $error("wr_stb long");
   chk_rd_pulse: assert property (rd_stb |=> !rd_stb)
      else $error("rd_stb long");
   chk_wr_input: assert property (wr_stb |-> !rd_stb && !sdio_oe)
      else $error("write drives");
   chk_hiz_off: assert property (port_hiz |-> !sdio_oe)
      else $error("hiz drives");
   chk_hiz_reset: assert property ($fell(rst) |-> port_hiz)
      else $error("no hiz");
   chk_out_fall: assert property (sdio_oe && $past(sdio_oe) && $changed(sdio_o) |-> !sclk)
      else $error("bit moved high");
   chk_oe_frame: assert property ($rose(sdio_oe) |-> busy && !cs_n)
      else $error("oe no frame");
endmodule // acsp_serial_port_sva
bind acsp_serial_port acsp_serial_port_sva acsp_serial_port_sva_i (.sys_clk, .rst, .sclk,
   .cs_n, .sdio_o, .sdio_oe, .wr_stb, .rd_stb, .port_hiz, .busy);

// [sim/acsp_host_model.sv]
`timescale 1ns/10ps
module acsp_host_model (
   input wire sys_clk,
   input wire sdio_o,
   input wire sdio_oe,
   output logic sclk = 1'h0,
   output logic cs_n = 1'h1,
   output logic sdio_i = 1'h0
);
   logic hb = 1'h0;
   logic hd = 1'h0;
   // Released line toggles so stale data never matches
   always @(posedge sys_clk) sdio_i <= sdio_oe ? sdio_o : hd ? hb : ~sdio_i;
   task bitx(input logic b, input logic d, output logic r);
      sclk <= 1'h0;
      hb <= b;
      hd <= d;
      repeat (10) @(posedge sys_clk);
      sclk <= 1'h1;
      repeat (10) @(posedge sys_clk);
      r = sdio_i;
   endtask
   task xfer(input logic [15:0] ins, input logic [31:0] d, input int nb, input bit gap,
      output logic [31:0] r);
      logic b;
      r = '0;
      cs_n <= 1'h0;
      for (int k = 0; k < 16; k++) bitx(ins[15-k], 1'h1, b);
      for (int k = 0; k < 8 * nb; k++) begin
         if (gap && k % 8 == 0) begin
            cs_n <= 1'h1;
            repeat (12) @(posedge sys_clk);
            cs_n <= 1'h0;
         end
         bitx(d[31-k], !ins[15], b);
         r[31-k] = b;
      end
      sclk <= 1'h0;
      hd <= 1'h0;
      repeat (10) @(posedge sys_clk);
      cs_n <= 1'h1;
      repeat (10) @(posedge sys_clk);
   endtask
endmodule // acsp_host_model

// [sim/tb.sv]
`timescale 1ns/10ps
module tb;
   typedef struct packed {logic rw; logic [1:0] len; logic [12:0] a; logic [31:0] d;
      logic [2:0] nb; logic [1:0] ch;} acsp_row_t;
   logic sys_clk = 1'h0;
   logic rst = 1'h1;
   logic lsb_first = 1'h0;
   logic [1:0] chan_sel = 2'h1;
   wire sclk, cs_n, sdio_i, sdio_o, sdio_oe, wr_stb, rd_stb, port_hiz, busy;
   wire [12:0] reg_addr;
   wire [7:0] wr_data;
   wire [7:0] rd_data_a = reg_addr[7:0] ^ 8'hA5;
   wire [7:0] rd_data_b = reg_addr[7:0] ^ 8'h3C;
   int n_mismatch = 0;
   int samples_checked = 0;
   logic [7:0] wq[$];
   logic [12:0] aq[$];
   acsp_row_t rows[6] = '{'{0, 0, 13'h005, 32'h5A000000, 1, 1},
      '{0, 1, 13'h010, 32'hC3810000, 2, 1}, '{0, 2, 13'h002, 32'hFF007E00, 3, 1},
      '{1, 0, 13'h012, 0, 1, 1}, '{1, 0, 13'h012, 0, 1, 2}, '{1, 1, 13'h034, 0, 2, 3}};
   acsp_serial_port #(.HIGH_IDLE_CYC(16'h0020)) acsp_serial_port_i (.sys_clk, .rst, .sclk,
      .cs_n, .sdio_i, .sdio_o, .sdio_oe, .lsb_first, .chan_sel, .rd_data_a, .rd_data_b,
      .reg_addr, .reg_chan(), .wr_data, .wr_stb, .rd_stb, .port_hiz, .busy);
   acsp_host_model acsp_host_model_i (.sys_clk, .sdio_o, .sdio_oe, .sclk, .cs_n, .sdio_i);
   initial forever #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (wr_stb) begin
      wq.push_back(wr_data);
      aq.push_back(reg_addr);
   end
   task chk(input logic [12:0] s, input logic [12:0] e);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: %h not %h", $time, s, e);
      end
   endtask
   task complete_run;
      $display("mismatches %0d of %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task run(input acsp_row_t t, input bit gap);
      logic [31:0] r;
      logic [7:0] e;
      logic [7:0] f;
      logic [12:0] av;
      wq = {};
      aq = {};
      chan_sel <= t.ch;
      acsp_host_model_i.xfer({t.rw, t.len, t.a}, t.d, t.nb, gap, r);
      if (!t.rw) chk(13'(wq.size()), 13'(t.nb));
      for (int k = 0; k < t.nb; k++) begin
         av = lsb_first ? 13'(t.a + k) : 13'(t.a - k);
         e = t.d[31-8*k -: 8];
         f = {<<{e}};
         if (t.rw) chk(r[31-8*k -: 8], av[7:0] ^ (t.ch == 2'h2 ? 8'h3C : 8'hA5));
         else chk(wq[k], lsb_first ? f : e);
         if (!t.rw) chk(aq[k], av);
      end
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'h0;
      repeat (4) @(posedge sys_clk);
      chk(port_hiz, 1'h1);
      chk(busy | sdio_oe, 1'h0);
      foreach (rows[i]) run(rows[i], 1'b0);
      run('{0, 3, 13'h020, 32'h11223344, 4, 1}, 1'h0);
      // A stream stays busy past the idle limit and only ends when select next falls
      repeat (40) @(posedge sys_clk);
      chk(busy, 1'h1);
      chk(port_hiz, 1'h1);
      run('{0, 1, 13'h040, 32'hA55A0000, 2, 1}, 1'h1);
      lsb_first <= 1'h1;
      run('{0, 1, 13'h100, 32'h0F300000, 2, 1}, 1'h0);
      repeat (40) @(posedge sys_clk);
      chk(port_hiz & ~sdio_oe, 1'h1);
      complete_run();
   end
endmodule // tb
